// ---- rtl/packet_descriptor_queue_dma.sv ----
// Purpose: Walks linked descriptor lists for 8 tx and 8 rx channels
// Assumes: Memory slave acks each mem request, which the engine holds until the ack
// Notes:   One engine shared by all channels, fixed priority
//
// Notes on behaviour
// - Descriptor is four words, fixed field layout
// - Start flag marks first or only buffer
// - End flag marks last or only buffer
// - Data address is buffer pointer plus offset; rx uses the buffer pointer alone
// - Length counts data, or empty rx capacity
// - Packet length valid only in data starts
// - Eight tx, eight rx head pointer registers
// - Ownership flag on start descriptors only
// - Clear ownership in start descriptor after packet
// - Head pointer write starts channel processing
// - Zero next pointer is only list end; an ownership error on a start descriptor also stops the list
// - Set end-of-queue on last with zero next
// - Same handling for tx and rx lists
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module packet_descriptor_queue_dma
    import dq_pkg::*;
(
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // APB slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic [31:0]           prdata,
    output logic                  pready,
    output logic                  pslverr,
    // Descriptor memory port
    output dq_pkg::mem_req_t      mem_o,
    input  wire dq_pkg::mem_rsp_t mem_i,
    // Buffer handoff to the MAC side
    output dq_pkg::buf_t          buf_o,
    input  wire logic             buf_ready,
    // Interrupt
    output logic                  irq
);
    import dq_pkg::*;

    typedef enum {S_IDLE, S_FETCH, S_CHECK, S_XFER, S_WEOQ, S_WOWN, S_NEXT} state_t;

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    logic [31:0]     head [NCH];
    logic [31:0]     next_head [NCH];
    logic [ST_W-1:0] status, next_status, mask, next_mask;
    logic            wr_en, rd_hit_head;
    logic [3:0]      reg_idx;
    logic [NCH-1:0]  busy;
    logic [ST_W-1:0] ev;

    assign wr_en       = psel && penable && pwrite;
    assign reg_idx     = paddr[5:2];
    assign rd_hit_head = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'h0);
    assign pready      = 1'b1;
    assign irq         = |(status & mask);

    always_comb begin
        prdata  = 32'h0000_0000;
        pslverr = 1'b0;
        if (rd_hit_head) begin
            prdata = head[reg_idx];
        end else if (paddr == STATUS_OFF) begin
            prdata = {29'h0, status};
        end else if (paddr == MASK_OFF) begin
            prdata = {29'h0, mask};
        end else if (paddr == BUSY_OFF) begin
            prdata = {16'h0, busy};
        end else begin
            pslverr = psel && penable;
        end
    end

    // ----------------------------------------
    // Engine
    // ----------------------------------------
    state_t      state, next_state;
    logic [3:0]  chan, next_chan;
    logic [1:0]  widx, next_widx;
    logic [31:0] dw [4];
    logic [31:0] next_dw [4];
    logic [31:0] sop_addr, next_sop_addr, sop_w3, next_sop_w3;
    mem_req_t    next_mem;
    buf_t        next_buf;
    logic        pick_ok;
    logic [3:0]  pick;
    logic [31:0] cur;
    logic        same_desc;

    assign cur       = head[chan];
    assign same_desc = (cur == sop_addr);

    always_comb begin
        pick_ok = 1'b0;
        pick    = 4'h0;
        // Lowest index wins; a busy low channel can starve higher ones
        for (int i = NCH - 1; i >= 0; i--) begin
            if (head[i] != 32'h0) begin
                pick_ok = 1'b1;
                pick    = 4'(i);
            end
        end
    end

    for (genvar g = 0; g < NCH; g++) begin : g_busy
        assign busy[g] = (head[g] != 32'h0);
    end

    always_comb begin
        next_state    = state;
        next_chan     = chan;
        next_widx     = widx;
        next_dw       = dw;
        next_sop_addr = sop_addr;
        next_sop_w3   = sop_w3;
        next_mem      = mem_o;
        next_buf      = buf_o;
        ev            = '0;
        for (int i = 0; i < NCH; i++) begin
            next_head[i] = head[i];
            // Writes land only on idle channels; an active list is left alone
            if (wr_en && rd_hit_head && reg_idx == 4'(i) && head[i] == 32'h0) begin
                next_head[i] = pwdata;
            end
        end
        case (state)
            S_IDLE: begin
                if (pick_ok) begin
                    next_chan  = pick;
                    next_widx  = 2'h0;
                    next_state = S_FETCH;
                end
            end
            S_FETCH: begin
                if (!mem_o.req) begin
                    next_mem.req   = 1'b1;
                    next_mem.we    = 1'b0;
                    next_mem.addr  = cur + {28'h0, widx, 2'h0};
                    next_mem.wdata = 32'h0;
                end else if (mem_i.ack) begin
                    next_mem.req  = 1'b0;
                    next_dw[widx] = mem_i.rdata;
                    next_widx     = widx + 2'h1;
                    if (widx == 2'h3) begin
                        next_state = S_CHECK;
                    end
                end
            end
            S_CHECK: begin
                if (dw[3][SOP_BIT]) begin
                    next_sop_addr = cur;
                    next_sop_w3   = dw[3];
                end
                if (dw[3][SOP_BIT] && !dw[3][OWN_BIT]) begin
                    // Not ours: stop the list so software can resubmit
                    ev[ST_OWNERR]   = 1'b1;
                    next_head[chan] = 32'h0;
                    next_state      = S_IDLE;
                end else begin
                    next_buf.valid = 1'b1;
                    next_buf.chan  = chan;
                    next_buf.rx    = chan[3];
                    // Rx buffers are empty, so offset is ignored there
                    next_buf.addr  = chan[3] ? dw[1] :
                                     dw[1] + {16'h0, dw[2][31:OFFSET_LSB]};
                    next_buf.len   = dw[2][LEN_MSB:0];
                    next_buf.sop   = dw[3][SOP_BIT];
                    next_buf.eop   = dw[3][EOP_BIT];
                    next_buf.pkt_len = (dw[3][SOP_BIT] && !chan[3]) ?
                                       dw[3][LEN_MSB:0] : 16'h0;
                    next_state     = S_XFER;
                end
            end
            S_XFER: begin
                if (buf_ready) begin
                    next_buf.valid = 1'b0;
                    if (!dw[3][EOP_BIT]) begin
                        next_state = S_NEXT;
                    end else if (dw[0] == 32'h0 && !same_desc) begin
                        next_state = S_WEOQ;
                    end else begin
                        next_state = S_WOWN;
                    end
                end
            end
            S_WEOQ: begin
                if (!mem_o.req) begin
                    next_mem.req   = 1'b1;
                    next_mem.we    = 1'b1;
                    next_mem.addr  = cur + W3_OFF;
                    next_mem.wdata = dw[3] | (32'h1 << EOQ_BIT);
                end else if (mem_i.ack) begin
                    next_mem.req = 1'b0;
                    next_state   = S_WOWN;
                end
            end
            S_WOWN: begin
                if (!mem_o.req) begin
                    next_mem.req   = 1'b1;
                    next_mem.we    = 1'b1;
                    next_mem.addr  = sop_addr + W3_OFF;
                    next_mem.wdata = (sop_w3 & ~(32'h1 << OWN_BIT)) |
                                     ((dw[0] == 32'h0 && same_desc) ?
                                      (32'h1 << EOQ_BIT) : 32'h0);
                end else if (mem_i.ack) begin
                    next_mem.req  = 1'b0;
                    ev[ST_PKT]    = 1'b1;
                    ev[ST_EOQ]    = (dw[0] == 32'h0);
                    next_state    = S_NEXT;
                end
            end
            S_NEXT: begin
                // Zero next pointer idles the channel for a new head write
                next_head[chan] = dw[0];
                next_widx       = 2'h0;
                if (dw[0] != 32'h0 && !dw[3][EOP_BIT]) begin
                    next_state = S_FETCH;
                end else begin
                    next_state = S_IDLE;
                end
            end
            default: next_state = S_IDLE;
        endcase
        // Set wins over a same-cycle clear
        next_status = status;
        next_mask   = mask;
        if (wr_en && paddr == STATUS_OFF) begin
            next_status = status & ~pwdata[ST_W-1:0];
        end
        if (wr_en && paddr == MASK_OFF) begin
            next_mask = pwdata[ST_W-1:0];
        end
        next_status = next_status | ev;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state    <= S_IDLE;
            chan     <= 4'h0;
            widx     <= 2'h0;
            sop_addr <= 32'h0;
            sop_w3   <= 32'h0;
            mem_o    <= '0;
            buf_o    <= '0;
            status   <= '0;
            mask     <= MASK_RST;
            for (int i = 0; i < 4; i++) begin
                dw[i] <= 32'h0;
            end
            for (int i = 0; i < NCH; i++) begin
                head[i] <= 32'h0;
            end
        end else begin
            state    <= next_state;
            chan     <= next_chan;
            widx     <= next_widx;
            sop_addr <= next_sop_addr;
            sop_w3   <= next_sop_w3;
            mem_o    <= next_mem;
            buf_o    <= next_buf;
            status   <= next_status;
            mask     <= next_mask;
            dw       <= next_dw;
            head     <= next_head;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    own_clear_a: assert property (
        state == S_WOWN && mem_o.req |-> mem_o.we && !mem_o.wdata[OWN_BIT]
        && mem_o.addr == sop_addr + W3_OFF)
        else $error("ownership not cleared in start descriptor");
    eoq_set_a: assert property (
        state == S_WEOQ && mem_o.req |-> mem_o.wdata[EOQ_BIT] && dw[0] == 32'h0)
        else $error("end-of-queue write without zero next");
    eoq_own_a: assert property (
        state == S_WOWN && mem_o.req |-> mem_o.wdata[EOQ_BIT] == (dw[0] == 32'h0 && same_desc))
        else $error("end-of-queue flag wrong in start write");
    head_start_a: assert property (
        state == S_IDLE && wr_en && rd_hit_head && head[reg_idx] == 32'h0
        && pwdata != 32'h0 |=> busy[$past(reg_idx)])
        else $error("head write did not start channel");
    idle_end_a: assert property (
        state == S_NEXT && dw[0] == 32'h0 |=> head[$past(chan)] == 32'h0 && state == S_IDLE)
        else $error("channel not idle after zero next");
    follow_a: assert property (
        state == S_NEXT |=> head[$past(chan)] == $past(dw[0]))
        else $error("head did not follow next pointer");
    buf_addr_a: assert property (
        buf_o.valid && !buf_o.rx |-> buf_o.addr == dw[1] + {16'h0, dw[2][31:OFFSET_LSB]})
        else $error("tx buffer address lacks offset");
    buf_len_a: assert property (
        buf_o.valid |-> buf_o.len == dw[2][LEN_MSB:0])
        else $error("buffer length mismatch");
    pkt_len_a: assert property (
        buf_o.valid && (!buf_o.sop || buf_o.rx) |-> buf_o.pkt_len == 16'h0)
        else $error("packet length outside data start");
    fetch_seq_a: assert property (
        state == S_FETCH && mem_o.req |-> mem_o.addr == cur + {28'h0, widx, 2'h0} && !mem_o.we)
        else $error("descriptor word address wrong");
    set_wins_a: assert property (
        ev[ST_PKT] |=> status[ST_PKT])
        else $error("packet event lost");

    single_pkt_c: cover property (state == S_WOWN && mem_o.req && same_desc);
    frag_pkt_c:   cover property (state == S_WEOQ && mem_o.req);
    own_err_c:    cover property (ev[ST_OWNERR]);
    rx_buf_c:     cover property (buf_o.valid && buf_o.rx && buf_ready);
endmodule

// ---- rtl/dq_pkg.sv ----
// Purpose: Constants and carriers for the descriptor queue engine
// Assumes: 32-bit APB, 32-bit descriptor memory port
// Notes:   Tx channels take indices 0..7, rx channels 8..15
package dq_pkg;
    localparam int          NCH_DIR      = 8;
    localparam int          NCH          = 2 * NCH_DIR;
    // Register byte offsets
    localparam logic [11:0] TX_HEAD_BASE = 12'h000;
    localparam logic [11:0] RX_HEAD_BASE = 12'h020;
    localparam logic [11:0] STATUS_OFF   = 12'h040;
    localparam logic [11:0] MASK_OFF     = 12'h044;
    localparam logic [11:0] BUSY_OFF     = 12'h048;
    // Descriptor word byte offsets
    localparam logic [31:0] W3_OFF       = 32'h0000_000C;
    localparam logic [31:0] WORD_BYTES   = 32'h0000_0004;
    // Word 2 and word 3 field positions
    localparam int          OFFSET_LSB   = 16;
    localparam int          LEN_MSB      = 15;
    localparam int          SOP_BIT      = 31;
    localparam int          EOP_BIT      = 30;
    localparam int          OWN_BIT      = 29;
    localparam int          EOQ_BIT      = 28;
    // Interrupt status bits
    localparam int          ST_PKT       = 0;
    localparam int          ST_EOQ       = 1;
    localparam int          ST_OWNERR    = 2;
    localparam int          ST_W         = 3;
    localparam logic [ST_W-1:0] MASK_RST = 3'h0;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mem_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
    } mem_rsp_t;

    typedef struct packed {
        logic        valid;
        logic [3:0]  chan;
        logic        rx;
        logic [31:0] addr;
        logic [15:0] len;
        logic        sop;
        logic        eop;
        logic [15:0] pkt_len;
    } buf_t;
endpackage

// ---- test/dq_mem_model.sv ----
// Purpose: Descriptor memory behind the queue engine memory port
// Assumes: Engine holds each request until it sees ack
// Notes:   Ack latency 0..3 extra cycles, chosen by the bench
`timescale 1ns/1ps
module dq_mem_model
    import dq_pkg::*;
(
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Engine side
    input  wire dq_pkg::mem_req_t mem_i,
    output dq_pkg::mem_rsp_t      mem_o,
    // Bench control
    input  wire logic [1:0]       lat
);
    logic [31:0] mem [0:255];
    logic [1:0]  wait_cnt;

    // One 32-bit word per request, four words per descriptor
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_o    <= '0;
            wait_cnt <= 2'h0;
        end else if (mem_i.req && !mem_o.ack && wait_cnt >= lat) begin
            mem_o.ack   <= 1'b1;
            mem_o.rdata <= mem[mem_i.addr[9:2]];
            wait_cnt    <= 2'h0;
            if (mem_i.we) begin
                mem[mem_i.addr[9:2]] <= mem_i.wdata;
            end
        end else begin
            mem_o.ack   <= 1'b0;
            // Data not valid outside ack: keep it moving
            mem_o.rdata <= ~mem_o.rdata;
            wait_cnt    <= (mem_i.req && !mem_o.ack) ? wait_cnt + 2'h1 : 2'h0;
        end
    end
endmodule

// ---- test/test_packet_descriptor_queue_dma.sv ----
// Purpose: Self-checking bench for the descriptor queue engine
// Assumes: APB slave may stall; memory model answers with random latency
// Notes:   Descriptor k sits at byte 0x40 + 16*k
`timescale 1ns/1ps
module test_packet_descriptor_queue_dma;
    import dq_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, buf_ready;
    logic        pready, pslverr, irq, err, hung;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, lfsr, rd;
    logic [1:0]  lat;
    mem_req_t    mem_req;
    mem_rsp_t    mem_rsp;
    buf_t        buf_o;
    buf_t        exp_q[$];
    int          err_count, total_checks;

    packet_descriptor_queue_dma u_packet_descriptor_queue_dma (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_o(mem_req),
        .mem_i(mem_rsp), .buf_o(buf_o), .buf_ready(buf_ready), .irq(irq));
    dq_mem_model u_dq_mem_model (.pclk(pclk), .presetn(presetn), .mem_i(mem_req),
        .mem_o(mem_rsp), .lat(lat));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    function automatic logic [31:0] nxt(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h0040_0007 : 32'h0);
    endfunction

    task automatic check(input logic [95:0] seen, input logic [95:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic apb(input logic we, input logic [11:0] a, input logic [31:0] d);
        int n;
        if (hung) return;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= we;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) begin
                rd  = prdata;
                err = pslverr;
                break;
            end
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n == 50) begin
            // Stalled slave: count it, skip further transfers, reach the report
            err_count++;
            hung = 1'b1;
        end
    endtask

    function automatic buf_t mk(input logic rx, input logic [3:0] ch,
                                input logic [31:0] bp, w2, w3);
        buf_t b;
        b.valid   = 1'b1;
        b.chan    = ch;
        b.rx      = rx;
        b.addr    = rx ? bp : bp + {16'h0, w2[31:OFFSET_LSB]};
        b.len     = w2[LEN_MSB:0];
        b.sop     = w3[SOP_BIT];
        b.eop     = w3[EOP_BIT];
        b.pkt_len = (!rx && w3[SOP_BIT]) ? w3[15:0] : 16'h0;
        return b;
    endfunction

    // Write a descriptor, queue the buffer it should produce if exp is set
    task automatic put(input int k, input logic rx, input logic [2:0] ch,
                       input logic [31:0] nx, bp, w2, w3, input logic exp);
        u_dq_mem_model.mem[16 + 4 * k]     = nx;
        u_dq_mem_model.mem[16 + 4 * k + 1] = bp;
        u_dq_mem_model.mem[16 + 4 * k + 2] = w2;
        u_dq_mem_model.mem[16 + 4 * k + 3] = w3;
        if (exp) begin
            exp_q.push_back(mk(rx, {rx, ch}, bp, w2, w3));
        end
    endtask

    task automatic run_list(input logic rx, input logic [2:0] ch, input logic [2:0] st,
                            input logic full, input logic split);
        int          n;
        logic [31:0] r, w30, w31, w32;
        r   = nxt(lfsr);
        w30 = {4'hA, 12'h0, 16'h0300};
        // Split: two packets, last one single; else one three-fragment packet
        w31 = {split ? 4'h4 : 4'h0, 12'h0, r[15:0]};
        w32 = {split ? 4'hE : 4'h4, 12'h0, 16'h0123};
        if (full) begin
            put(0, rx, ch, 32'h50, r, {r[15:8], 8'h0, 16'h0100}, w30, 1'b1);
            put(1, rx, ch, 32'h60, ~r, {8'h0, r[7:0], 16'h0200}, w31, 1'b1);
            put(2, rx, ch, 32'h0, r ^ 32'h5A, {16'h0, 16'h0123}, w32, 1'b1);
        end else begin
            put(0, rx, ch, 32'h0, r, 32'h0004_0010, {4'hC, 28'h40}, 1'b0);
        end
        apb(1'b1, (rx ? RX_HEAD_BASE : TX_HEAD_BASE) + {7'h0, ch, 2'h0}, 32'h40);
        // Head is written again only after busy shows the list ended
        for (n = 0; n < 200; n++) begin
            apb(1'b0, BUSY_OFF, 32'h0);
            if (rd === 32'h0) break;
        end
        check(n < 200, 1'b1);
        check(exp_q.size(), 0);
        if (full) begin
            check(u_dq_mem_model.mem[19], w30 & ~(32'h1 << OWN_BIT));
            check(u_dq_mem_model.mem[23], w31);
            check(u_dq_mem_model.mem[27],
                  (w32 & ~(32'h1 << OWN_BIT)) | (32'h1 << EOQ_BIT));
        end
        apb(1'b1, MASK_OFF, {29'h0, r[20:18]});
        apb(1'b0, STATUS_OFF, 32'h0);
        check(rd, {29'h0, st});
        check(irq, |(st & r[20:18]));
        apb(1'b1, STATUS_OFF, 32'h7);
        apb(1'b0, STATUS_OFF, 32'h0);
        check({rd, irq}, 33'h0);
        apb(1'b0, (rx ? RX_HEAD_BASE : TX_HEAD_BASE) + {7'h0, ch, 2'h0}, 32'h0);
        check(rd, 32'h0);
    endtask

    // Drawn ready and memory latency stall the engine now and then
    always @(posedge pclk) begin
        lfsr      <= nxt(lfsr);
        buf_ready <= lfsr[0] | lfsr[1];
        lat       <= lfsr[3:2];
        if (buf_o.valid && buf_ready) begin
            if (exp_q.size() == 0) begin
                check(96'(buf_o), 96'h0);
            end else begin
                check(96'(buf_o), 96'(exp_q.pop_front()));
            end
        end
    end

    initial begin
        presetn   = 1'b0;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 12'h0;
        pwdata    = 32'h0;
        buf_ready = 1'b0;
        lat       = 2'h0;
        lfsr      = 32'h8265;
        hung      = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, MASK_OFF, 32'h0);
        check(rd, 32'h0);
        for (int i = 0; i < NCH; i++) begin
            apb(1'b1, 12'(4 * i), 32'h0);
            apb(1'b0, 12'(4 * i), 32'h0);
            check(rd, 32'h0);
        end
        apb(1'b1, 12'h100, 32'h1);
        check(err, 1'b1);
        apb(1'b0, 12'h100, 32'h0);
        check({err, rd}, 33'h1_0000_0000);
        for (int i = 0; i < 8; i++) begin
            run_list(i[0], lfsr[6:4], 3'h3, 1'b1, i[1]);
        end
        run_list(1'b1, 3'h7, 3'h4, 1'b0, 1'b0);
        stop_test();
    end
endmodule
